//--- core/eeprom_capability_regs.sv
// eeprom access word and express capability words of one switch port
// assumes a one-cycle config access strobe; autoload engine on same clock
//
// Function
// - start bit launches one eeprom cycle
// - command bit: 0 read, 1 write
// - missing acknowledge sets error flag
// - autoload success bit clears on read
// - autoload status reports outcome after reset
// - autoload disable bit, resets to one
// - clock rate field divides core clock
// - address field at bits 15:9
// - data field written or loaded by read
// - access word exists only upstream
// - capability id 10h, next pointer 00h
// - capability version reads 0010b
// - port type by upstream or downstream
// - slot bit from strap, load overrides
// - interrupt message number reads zero
// - max payload from strap, load overrides
// - phantom and extended tag read zero
// - latency fields read zero
// - role based error bit resets one
// - slot power captured from message upstream
`timescale 1ns/100ps
module eeprom_capability_regs #(
	parameter bit UPSTREAM = 1'b1  // port is the upstream port
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        cfg_rd_in,
	input  wire logic        cfg_wr_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [3:0]  cfg_be_in,
	input  wire logic [31:0] cfg_wdata_in,
	output logic      [31:0] cfg_rdata_out,
	output logic             cfg_ack_out,
	input  wire logic        slot_present_strap_in,
	input  wire logic        large_payload_strap_in,
	input  wire logic        autoload_done_in,
	input  wire logic        autoload_ok_in,
	input  wire logic        cap_load_in,
	input  wire logic        cap_load_slot_in,
	input  wire logic [2:0]  cap_load_mps_in,
	input  wire logic        cap_load_rber_in,
	input  wire logic        spl_msg_in,
	input  wire logic [7:0]  spl_value_in,
	input  wire logic [1:0]  spl_scale_in,
	output logic             autoload_disable_out,
	input  wire logic        eeprom_data_in,
	output logic             eeprom_data_out,
	output logic             eeprom_data_oe_out,
	output logic             eeprom_clock_out
);
	// ---------------------------------------------
	// storage
	// ---------------------------------------------
	logic        start_reg;   // access in flight
	logic        cmd_reg;     // 1 write, 0 read
	logic        err_reg;     // acknowledge missing
	logic        al_rc_reg;   // autoload ok, clear on read
	logic        al_stat_reg; // autoload ok
	logic        al_dis_reg;  // autoload disabled
	logic [1:0]  rate_reg;    // eeprom clock rate
	logic [6:0]  addr_reg;    // eeprom word address
	logic [15:0] data_reg;    // eeprom word data
	logic        slot_reg;    // slot implemented
	logic [2:0]  mps_reg;     // max payload supported
	logic        rber_reg;    // role based errors
	logic [7:0]  spl_val_reg; // slot power value
	logic [1:0]  spl_scl_reg; // slot power scale
	logic [2:0]  slot_s_reg;  // strap synchroniser
	logic [2:0]  pay_s_reg;   // strap synchroniser
	logic [1:0]  fill_reg;    // synchroniser fill count
	logic        strap_reg;   // straps captured
	logic [31:0] rd_word;     // read mux
	logic        ee_wr;       // write to access word
	logic        ee_rd;       // read of access word
	logic        go;          // launch pulse
	eeprom_cmd_if link ();

	// ---------------------------------------------
	// decode
	// ---------------------------------------------
	// access word upstream only
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	assign ee_wr = UPSTREAM && cfg_wr_in && hit(cfg_addr_in, eeprom_cap_pkg::EE_CTRL_OFFSET);
	assign ee_rd = UPSTREAM && cfg_rd_in && hit(cfg_addr_in, eeprom_cap_pkg::EE_CTRL_OFFSET);
	assign go = ee_wr && cfg_be_in[0] && cfg_wdata_in[eeprom_cap_pkg::START_BIT] && !start_reg;

	// ---------------------------------------------
	// access control
	// ---------------------------------------------
	// start, command and rate; writes ignored while busy so the engine
	// never sees its operands change mid-frame
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			start_reg <= 1'b0;
			cmd_reg   <= 1'b0;
			rate_reg  <= eeprom_cap_pkg::RATE_RESET;
		end else if (go) begin
			start_reg <= 1'b1;
			cmd_reg   <= cfg_wdata_in[eeprom_cap_pkg::CMD_BIT];
			rate_reg  <= cfg_wdata_in[eeprom_cap_pkg::RATE_LSB +: 2];
		end else if (link.done) begin
			start_reg <= 1'b0;
		end else if (ee_wr && cfg_be_in[0] && !start_reg) begin
			cmd_reg  <= cfg_wdata_in[eeprom_cap_pkg::CMD_BIT];
			rate_reg <= cfg_wdata_in[eeprom_cap_pkg::RATE_LSB +: 2];
		end
	end

	// autoload disable may change at any time
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			al_dis_reg <= eeprom_cap_pkg::AL_DIS_RESET;
		end else if (ee_wr && cfg_be_in[0]) begin
			al_dis_reg <= cfg_wdata_in[eeprom_cap_pkg::AL_DIS_BIT];
		end
	end

	// error flag: cleared by a new launch, set on a missing acknowledge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			err_reg <= 1'b0;
		end else if (link.done) begin
			err_reg <= link.ack_err;
		end else if (go) begin
			err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_reg <= '0;
		end else if (ee_wr && cfg_be_in[1] && !start_reg) begin
			addr_reg <= cfg_wdata_in[eeprom_cap_pkg::ADDR_LSB +: 7];
		end
	end

	// data word: software writes when idle, a finished read loads it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			data_reg <= '0;
		end else if (link.done && !cmd_reg) begin
			data_reg <= link.rdata;
		end else if (ee_wr && !start_reg) begin
			if (cfg_be_in[2]) data_reg[7:0] <= cfg_wdata_in[eeprom_cap_pkg::DATA_LSB +: 8];
			if (cfg_be_in[3]) data_reg[15:8] <= cfg_wdata_in[eeprom_cap_pkg::DATA_LSB + 8 +: 8];
		end
	end

	// ---------------------------------------------
	// autoload result
	// ---------------------------------------------
	// a success that lands with the clearing read is kept
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			al_rc_reg   <= 1'b0;
			al_stat_reg <= 1'b0;
		end else begin
			if (autoload_done_in && autoload_ok_in) al_rc_reg <= 1'b1;
			else if (ee_rd) al_rc_reg <= 1'b0;
			if (autoload_done_in) al_stat_reg <= autoload_ok_in;
		end
	end

	// ---------------------------------------------
	// capability fields
	// ---------------------------------------------
	// straps are pins: three flops, sampled once both tail flops agree;
	// the fill count keeps the flops' reset value from posing as a strap
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			slot_s_reg <= '0;
			pay_s_reg  <= '0;
			fill_reg   <= '0;
		end else begin
			slot_s_reg <= {slot_s_reg[1:0], slot_present_strap_in};
			pay_s_reg  <= {pay_s_reg[1:0], large_payload_strap_in};
			if (fill_reg != 2'd3) fill_reg <= fill_reg + 2'd1;
		end
	end

	// strap capture after reset, later loads override
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			strap_reg <= 1'b0;
			slot_reg  <= 1'b0;
			mps_reg   <= eeprom_cap_pkg::MPS_SMALL;
			rber_reg  <= eeprom_cap_pkg::RBER_RESET;
		end else if (cap_load_in) begin
			strap_reg <= 1'b1;
			slot_reg  <= cap_load_slot_in;
			mps_reg   <= cap_load_mps_in;
			rber_reg  <= cap_load_rber_in;
		end else if (!strap_reg && fill_reg == 2'd3 && slot_s_reg[1] == slot_s_reg[2]
				&& pay_s_reg[1] == pay_s_reg[2]) begin
			strap_reg <= 1'b1;
			slot_reg  <= slot_s_reg[2];
			mps_reg   <= pay_s_reg[2] ? eeprom_cap_pkg::MPS_LARGE : eeprom_cap_pkg::MPS_SMALL;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			spl_val_reg <= '0;
			spl_scl_reg <= '0;
		end else if (UPSTREAM && spl_msg_in) begin
			spl_val_reg <= spl_value_in;
			spl_scl_reg <= spl_scale_in;
		end
	end

	// ---------------------------------------------
	// read path
	// ---------------------------------------------
	always_comb begin
		rd_word = '0;
		if (hit(cfg_addr_in, eeprom_cap_pkg::EE_CTRL_OFFSET) && UPSTREAM) begin
			// bit 8 is reserved and reads zero
			rd_word = {data_reg, addr_reg, 1'b0, rate_reg, al_dis_reg,
				al_stat_reg, al_rc_reg, err_reg, cmd_reg, start_reg};
		end else if (hit(cfg_addr_in, eeprom_cap_pkg::CAP_HDR_OFFSET)) begin
			// fixed header; version; type; no msi
			rd_word = {7'h00, slot_reg,
				UPSTREAM ? eeprom_cap_pkg::TYPE_UP : eeprom_cap_pkg::TYPE_DN,
				eeprom_cap_pkg::CAP_VER, eeprom_cap_pkg::NEXT_PTR, eeprom_cap_pkg::CAP_ID};
		end else if (hit(cfg_addr_in, eeprom_cap_pkg::DEV_CAP_OFFSET)) begin
			rd_word = {4'h0, spl_scl_reg, spl_val_reg, 2'h0, rber_reg,
				3'h0, 3'h0, 3'h0, 1'b0, 2'h0, mps_reg};
		end
	end

	// answer one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_rdata_out <= '0;
			cfg_ack_out   <= 1'b0;
		end else begin
			cfg_ack_out <= cfg_rd_in | cfg_wr_in;
			if (cfg_rd_in) cfg_rdata_out <= rd_word;
		end
	end

	assign autoload_disable_out = al_dis_reg;

	// ---------------------------------------------
	// serial engine
	// ---------------------------------------------
	assign link.go    = go;
	assign link.write = cfg_wdata_in[eeprom_cap_pkg::CMD_BIT] & go | cmd_reg & ~go;
	assign link.addr  = addr_reg;
	assign link.wdata = data_reg;
	assign link.rate  = go ? cfg_wdata_in[eeprom_cap_pkg::RATE_LSB +: 2] : rate_reg;

	eeprom_serial_engine engine_i (
		.clk_in             (clk_in),
		.rst_in             (rst_in),
		.cmd                (link),
		.eeprom_data_in     (eeprom_data_in),
		.eeprom_data_out    (eeprom_data_out),
		.eeprom_data_oe_out (eeprom_data_oe_out),
		.eeprom_clock_out   (eeprom_clock_out)
	);

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_go_sets_start: assert property (@(posedge clk_in) disable iff (rst_in)
		go |=> start_reg ##1 !link.go)
		else $error("start not taken");
	a_done_clears: assert property (@(posedge clk_in) disable iff (rst_in)
		link.done |=> !start_reg)
		else $error("start not cleared at end");
	a_err_capture: assert property (@(posedge clk_in) disable iff (rst_in)
		link.done |=> err_reg == $past(link.ack_err))
		else $error("error flag wrong");
	a_read_loads: assert property (@(posedge clk_in) disable iff (rst_in)
		(link.done && !cmd_reg) |=> data_reg == $past(link.rdata))
		else $error("read word not loaded");
	a_rc_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		(ee_rd && !autoload_done_in) |=> !al_rc_reg)
		else $error("success bit not cleared by read");
	a_stat_track: assert property (@(posedge clk_in) disable iff (rst_in)
		autoload_done_in |=> al_stat_reg == $past(autoload_ok_in))
		else $error("autoload status wrong");
	a_hdr_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
		(cfg_rd_in && hit(cfg_addr_in, eeprom_cap_pkg::CAP_HDR_OFFSET))
		|=> cfg_rdata_out[19:0] == 20'h20010 && cfg_rdata_out[31:25] == 7'h00)
		else $error("capability header wrong");
	a_port_type: assert property (@(posedge clk_in) disable iff (rst_in)
		(cfg_rd_in && hit(cfg_addr_in, eeprom_cap_pkg::CAP_HDR_OFFSET))
		|=> cfg_rdata_out[23:20] == (UPSTREAM ? 4'h5 : 4'h6))
		else $error("port type wrong");
	a_devcap_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		(cfg_rd_in && hit(cfg_addr_in, eeprom_cap_pkg::DEV_CAP_OFFSET))
		|=> cfg_rdata_out[11:3] == 9'h000 && cfg_rdata_out[31:28] == 4'h0)
		else $error("fixed capability bits not zero");
	a_busy_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		start_reg && !link.done |=> $stable(addr_reg))
		else $error("address changed during access");
endmodule : eeprom_capability_regs

//--- core/eeprom_serial_engine.sv
// two-wire serial engine running one 16-bit eeprom word access
// assumes the controller holds write, addr, wdata and rate stable while busy
`timescale 1ns/100ps
module eeprom_serial_engine (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	eeprom_cmd_if.engine      cmd,
	input  wire logic         eeprom_data_in,
	output logic              eeprom_data_out,
	output logic              eeprom_data_oe_out,
	output logic              eeprom_clock_out
);
	eeprom_cap_pkg::ee_state_t state_reg; // sequencer state
	logic [9:0]  div_reg;   // phase divider
	logic [1:0]  phase_reg; // quarter of a bit
	logic [1:0]  byte_reg;  // byte in frame
	logic [3:0]  bit_reg;   // bit in byte, 8 = ack
	logic [7:0]  shift_reg; // outgoing byte
	logic [15:0] rx_reg;    // incoming word
	logic        err_reg;   // sticky ack error
	logic        scl_reg;   // clock pin level
	logic        low_reg;   // pull data low
	logic [2:0]  sync_reg;  // data pin synchroniser
	logic        sda_q;     // filtered data pin
	logic        tick;      // phase enable
	logic        talk;      // master sends this byte
	logic [9:0]  phase_len;

	// ---------------------------------------------
	// byte source
	// ---------------------------------------------
	// address in first byte
	function automatic logic [7:0] frame_byte(input logic [1:0] idx);
		frame_byte = (idx == 2'd0) ? {cmd.addr, cmd.write} :
			(idx == 2'd1) ? cmd.wdata[15:8] : cmd.wdata[7:0];
	endfunction : frame_byte

	// ---------------------------------------------
	// clock divider
	// ---------------------------------------------
	// rate code divides core
	assign phase_len = (cmd.rate == eeprom_cap_pkg::RATE_TEST) ?
		eeprom_cap_pkg::TEST_PHASE : eeprom_cap_pkg::CORE_PHASE;
	assign tick = (div_reg == phase_len - 10'd1);
	// divider only runs during an access
	always_ff @(posedge clk_in) begin
		if (rst_in || state_reg == eeprom_cap_pkg::ST_IDLE || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 10'd1;
		end
	end

	// pin passes three flops; change counts when last two agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync_reg <= 3'h7;
			sda_q    <= 1'b1;
		end else begin
			sync_reg <= {sync_reg[1:0], eeprom_data_in};
			if (sync_reg[1] == sync_reg[2]) begin
				sda_q <= sync_reg[2];
			end
		end
	end

	assign talk = (byte_reg == 2'd0) || cmd.write;

	// ---------------------------------------------
	// sequencer
	// ---------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= eeprom_cap_pkg::ST_IDLE;
			phase_reg <= '0;
			byte_reg  <= '0;
			bit_reg   <= '0;
			shift_reg <= '0;
			rx_reg    <= '0;
			err_reg   <= 1'b0;
			scl_reg   <= 1'b1;
			low_reg   <= 1'b0;
		end else begin
			unique case (state_reg)
				eeprom_cap_pkg::ST_IDLE: begin
					scl_reg <= 1'b1;
					low_reg <= 1'b0;
					if (cmd.go) begin
						state_reg <= eeprom_cap_pkg::ST_START;
						phase_reg <= '0;
						err_reg   <= 1'b0;
						byte_reg  <= '0;
						bit_reg   <= '0;
					end
				end
				// start: data falls while clock high
				eeprom_cap_pkg::ST_START: if (tick) begin
					phase_reg <= phase_reg + 2'd1;
					if (phase_reg == 2'd1) low_reg <= 1'b1;
					if (phase_reg == 2'd2) scl_reg <= 1'b0;
					if (phase_reg == 2'd3) begin
						state_reg <= eeprom_cap_pkg::ST_BITS;
						shift_reg <= frame_byte(2'd0);
					end
				end
				eeprom_cap_pkg::ST_BITS: if (tick) begin
					phase_reg <= phase_reg + 2'd1;
					unique case (phase_reg)
						// set data while clock low
						2'd0: begin
							scl_reg <= 1'b0;
							if (bit_reg != 4'd8) low_reg <= talk & ~shift_reg[7];
							else low_reg <= ~talk & (byte_reg == 2'd1);
						end
						2'd1: scl_reg <= 1'b1;
						2'd2: begin
							if (bit_reg != 4'd8 && !talk) rx_reg <= {rx_reg[14:0], sda_q};
							if (bit_reg == 4'd8 && talk && sda_q) err_reg <= 1'b1;
						end
						2'd3: begin
							scl_reg <= 1'b0;
							if (bit_reg != 4'd8) begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								bit_reg   <= bit_reg + 4'd1;
							end else begin
								bit_reg <= '0;
								if (byte_reg == 2'd2) begin
									state_reg <= eeprom_cap_pkg::ST_STOP;
								end else begin
									byte_reg  <= byte_reg + 2'd1;
									shift_reg <= frame_byte(byte_reg + 2'd1);
								end
							end
						end
					endcase
				end
				// stop: data rises while clock high
				eeprom_cap_pkg::ST_STOP: if (tick) begin
					phase_reg <= phase_reg + 2'd1;
					if (phase_reg == 2'd0) low_reg <= 1'b1;
					if (phase_reg == 2'd1) scl_reg <= 1'b1;
					if (phase_reg == 2'd2) low_reg <= 1'b0;
					if (phase_reg == 2'd3) state_reg <= eeprom_cap_pkg::ST_DONE;
				end
				eeprom_cap_pkg::ST_DONE: state_reg <= eeprom_cap_pkg::ST_IDLE;
				default: state_reg <= eeprom_cap_pkg::ST_IDLE;
			endcase
		end
	end

	assign cmd.rdata        = rx_reg;
	assign cmd.ack_err      = err_reg;
	assign cmd.done         = (state_reg == eeprom_cap_pkg::ST_DONE);
	assign eeprom_data_out  = 1'b0;
	assign eeprom_data_oe_out = low_reg;
	assign eeprom_clock_out = scl_reg;

	// idle bus is released with clock high
	a_idle_release: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == eeprom_cap_pkg::ST_IDLE && !cmd.go) |=> (scl_reg && !low_reg))
		else $error("bus not released while idle");
endmodule : eeprom_serial_engine

//--- include/eeprom_cap_pkg.sv
// constants for the eeprom access and express capability register slice
// assumes a 32-bit dword configuration access with byte offsets
package eeprom_cap_pkg;
	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [7:0] EE_CTRL_OFFSET = 8'hBC;
	localparam logic [7:0] CAP_HDR_OFFSET = 8'hC0;
	localparam logic [7:0] DEV_CAP_OFFSET = 8'hC4;
	// ---------------------------------------------
	// control word field positions
	// ---------------------------------------------
	localparam int START_BIT  = 0;
	localparam int CMD_BIT    = 1;
	localparam int AL_DIS_BIT = 5;
	localparam int RATE_LSB   = 6;
	localparam int ADDR_LSB   = 9;
	localparam int DATA_LSB   = 16;
	// ---------------------------------------------
	// reset values and codes
	// ---------------------------------------------
	localparam logic       AL_DIS_RESET = 1'b1;
	localparam logic [1:0] RATE_RESET   = 2'h1;
	localparam logic [1:0] RATE_TEST    = 2'h3;
	localparam logic [7:0] CAP_ID       = 8'h10;
	localparam logic [7:0] NEXT_PTR     = 8'h00;
	localparam logic [3:0] CAP_VER      = 4'h2;
	localparam logic [3:0] TYPE_UP      = 4'h5;
	localparam logic [3:0] TYPE_DN      = 4'h6;
	localparam logic [2:0] MPS_SMALL    = 3'h1;
	localparam logic [2:0] MPS_LARGE    = 3'h2;
	localparam logic       RBER_RESET   = 1'b1;
	// ---------------------------------------------
	// timing: eeprom bit = four phases of div/4
	// ---------------------------------------------
	localparam int CORE_DIV = 1024;
	localparam int TEST_DIV = 8;
	localparam logic [9:0] CORE_PHASE = 10'(CORE_DIV / 4);
	localparam logic [9:0] TEST_PHASE = 10'(TEST_DIV / 4);
	// serial sequencer states, gray from idle through done
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BITS  = 3'b011,
		ST_STOP  = 3'b010,
		ST_DONE  = 3'b110
	} ee_state_t;
endpackage : eeprom_cap_pkg

//--- include/eeprom_cmd_if.sv
// command and result bundle between the register slice and the serial engine
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface eeprom_cmd_if;
	logic        go;      // one-cycle start pulse
	logic        write;   // 1 write, 0 read
	logic [6:0]  addr;    // eeprom word address
	logic [15:0] wdata;   // word to write
	logic [1:0]  rate;    // clock rate code
	logic        done;    // one-cycle end pulse
	logic        ack_err; // missing acknowledge seen
	logic [15:0] rdata;   // word read
	modport ctrl (output go, write, addr, wdata, rate, input done, ack_err, rdata);
	modport engine (input go, write, addr, wdata, rate, output done, ack_err, rdata);
endinterface : eeprom_cmd_if

//--- verif/eeprom_access_and_pcie_capability_regs_bench.sv
// self-checking bench for the eeprom access and capability slice
// assumes the partner model and a pulled-up serial data line
`timescale 1ns/100ps
module eeprom_access_and_pcie_capability_regs_bench;
	logic clk_in = 0, rst_in = 1, rd = 0, wr = 0, ack, al_dis, sdo, oe, scl, pull;
	logic al_done = 0, al_ok = 0, ld = 0, ld_slot = 0, ld_rber = 0, spl = 0, nack = 0;
	logic [7:0]  addr = 0, spl_v = 0;
	logic [1:0]  spl_s = 0;
	logic [2:0]  ld_mps = 0;
	logic [31:0] wdat = 0, rdat, got, seed = 98332;
	logic [15:0] mem [128], d;
	logic [6:0]  a;
	logic [31:0] rdat_dn; // downstream port read word
	int          n_errors = 0, tests_run = 0;
	wire         slot = seed[2], lpay = seed[3];
	wire         sda = ~(oe | pull); // pulled up open drain
	eeprom_capability_regs dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_rd_in(rd),
		.cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_be_in(4'hF), .cfg_wdata_in(wdat),
		.cfg_rdata_out(rdat), .cfg_ack_out(ack), .slot_present_strap_in(slot),
		.large_payload_strap_in(lpay), .autoload_done_in(al_done), .autoload_ok_in(al_ok),
		.cap_load_in(ld), .cap_load_slot_in(ld_slot), .cap_load_mps_in(ld_mps),
		.cap_load_rber_in(ld_rber), .spl_msg_in(spl), .spl_value_in(spl_v),
		.spl_scale_in(spl_s), .autoload_disable_out(al_dis), .eeprom_data_in(sda),
		.eeprom_data_out(sdo), .eeprom_data_oe_out(oe), .eeprom_clock_out(scl));
	eeprom_model partner (.scl_in(scl), .sda_in(sda), .nack_in(nack), .pull_low_out(pull));
	// downstream port copy on the same bus: no access word, other port type
	eeprom_capability_regs #(.UPSTREAM(1'b0)) dut_dn (.clk_in(clk_in), .rst_in(rst_in),
		.cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_be_in(4'hF),
		.cfg_wdata_in(wdat), .cfg_rdata_out(rdat_dn), .cfg_ack_out(),
		.slot_present_strap_in(slot), .large_payload_strap_in(lpay),
		.autoload_done_in(al_done), .autoload_ok_in(al_ok), .cap_load_in(ld),
		.cap_load_slot_in(ld_slot), .cap_load_mps_in(ld_mps), .cap_load_rber_in(ld_rber),
		.spl_msg_in(spl), .spl_value_in(spl_v), .spl_scale_in(spl_s),
		.autoload_disable_out(), .eeprom_data_in(1'b1), .eeprom_data_out(),
		.eeprom_data_oe_out(), .eeprom_clock_out());
	initial forever #5 clk_in = ~clk_in;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] bc(input logic [1:0] r, input logic [5:0] lo);
		return {d, a, 1'b0, r, lo};
	endfunction : bc
	function automatic logic [31:0] c4(input logic [2:0] m, input logic rb);
		return {4'h0, spl_s, spl_v, 2'h0, rb, 12'h000, m};
	endfunction : c4
	task automatic check(input logic [31:0] g, e, input string m);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : check
	// one config access; ack must follow one cycle after the strobe
	task automatic cfg(input logic w, input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk_in);
		rd <= !w;
		wr <= w;
		addr <= ad;
		wdat <= v;
		@(posedge clk_in);
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
		check({31'h0, ack}, 32'h1, "ack");
		got = rdat;
	endtask : cfg
	// launch, time the serial clock, optionally poke while busy, poll, compare
	task automatic access(input logic c, r1, x, e);
		logic [31:0] v;
		realtime     t;
		int          n;
		v = bc(r1 ? 2'h1 : 2'h3, {4'b1000, c, 1'b1});
		n = 0;
		cfg(1'b1, 8'hBC, v);
		repeat (2) @(posedge scl);
		t = $realtime;
		@(posedge scl);
		check(32'(int'(($realtime - t) / 10)), r1 ? 1024 : 8, "rate");
		if (x) cfg(1'b1, 8'hBC, ~v & 32'hFFFF_FFDE);
		do begin
			cfg(1'b0, 8'hBC, 0);
			n++;
		end while (got[0] !== 1'b0 && n < 20000);
		if (c) mem[a] = d;
		else d = mem[a];
		check(got, bc(r1 ? 2'h1 : 2'h3, {!x, 2'b00, e, c, 1'b0}), "access");
		check({31'h0, al_dis}, {31'h0, !x}, "disable pin");
	endtask : access
	task automatic pulse(input logic ok);
		@(posedge clk_in);
		al_done <= 1'b1;
		al_ok <= ok;
		@(posedge clk_in);
		al_done <= 1'b0;
	endtask : pulse
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		#500_000;
		n_errors++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		cfg(1'b0, 8'hBC, 0);
		check(got, 32'h60, "ctrl reset");
		cfg(1'b1, 8'hC0, 32'hFFFF_FFFF);
		cfg(1'b0, 8'hC0, 0);
		check(got, {7'h00, slot, 16'h5200, 8'h10}, "cap hdr");
		check(rdat_dn, {7'h00, slot, 16'h6200, 8'h10}, "dn hdr");
		cfg(1'b0, 8'hC4, 0);
		check(got, c4(lpay ? 3'h2 : 3'h1, 1'b1), "dev cap");
		cfg(1'b0, 8'hC8, 0);
		check(got, 0, "unmapped");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			a = seed[6:0];
			d = seed[22:7];
			access(1'b1, 1'b0, i == 2, 1'b0);
			access(1'b0, 1'b0, 1'b0, 1'b0);
		end
		nack <= 1'b1;
		access(1'b1, 1'b0, 1'b0, 1'b1);
		nack <= 1'b0;
		access(1'b1, 1'b1, 1'b0, 1'b0);
		pulse(1'b1);
		cfg(1'b0, 8'hBC, 0);
		check({30'h0, got[4:3]}, 32'h3, "autoload ok");
		cfg(1'b0, 8'hBC, 0);
		check({30'h0, got[4:3]}, 32'h2, "clear on read");
		pulse(1'b0);
		cfg(1'b0, 8'hBC, 0);
		check({30'h0, got[4:3]}, 32'h0, "autoload fail");
		check(rdat_dn, 32'h0, "dn ctrl");
		seed = lfsr(seed);
		@(posedge clk_in);
		{ld_slot, ld_mps, ld_rber, spl_v, spl_s} <= seed[14:0];
		ld <= 1'b1;
		spl <= 1'b1;
		@(posedge clk_in);
		ld <= 1'b0;
		spl <= 1'b0;
		cfg(1'b0, 8'hC0, 0);
		check(got, {7'h00, ld_slot, 16'h5200, 8'h10}, "slot load");
		check(rdat_dn, {7'h00, ld_slot, 16'h6200, 8'h10}, "dn slot load");
		cfg(1'b0, 8'hC4, 0);
		check(got, c4(ld_mps, ld_rber), "cap load");
		check(rdat_dn, {16'h0, ld_rber, 12'h000, ld_mps}, "dn no slot power");
		check({31'h0, sdo}, 32'h0, "data pin only pulls low");
		final_report();
	end
endmodule : eeprom_access_and_pcie_capability_regs_bench

//--- verif/eeprom_model.sv
// serial eeprom partner: word store, acks every byte unless refusing
// assumes the data line is pulled up outside the model
`timescale 1ns/100ps
module eeprom_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic nack_in,
	output logic      pull_low_out
);
	logic [15:0] mem [128]; // word store
	logic [7:0]  b0;        // address and command byte
	logic [15:0] w;         // word in flight
	// shift one byte in, msb first, on rising clock
	task automatic get(output logic [7:0] b);
		repeat (8) @(posedge scl_in) b = {b[6:0], sda_in};
	endtask : get
	// hold the line low for one ack slot, or leave it high when refusing
	task automatic ack();
		@(negedge scl_in) pull_low_out = !nack_in;
		@(negedge scl_in) pull_low_out = 1'b0;
	endtask : ack
	initial begin
		pull_low_out = 1'b0;
		forever begin
			// frame opens when data falls with clock high
			@(negedge sda_in iff scl_in);
			get(b0);
			if (b0[0]) begin
				ack();
				get(w[15:8]);
				ack();
				get(w[7:0]);
				ack();
				mem[b0[7:1]] = w;
			end else begin
				@(negedge scl_in) pull_low_out = !nack_in;
				w = mem[b0[7:1]];
				// high byte, master ack slot, low byte, then let go
				for (int k = 0; k < 18; k++)
					@(negedge scl_in) pull_low_out = (k == 8 || k == 17) ? 1'b0
						: !w[k < 8 ? 15 - k : 16 - k];
			end
		end
	end
endmodule : eeprom_model
